// *** src/csic_i2c_ctrl.sv ***
// Two-wire serial control port of a dual-loop clock synthesizer, with its byte FIFO.
// Assumes a 250 MHz reference clock, a synchronous reset, and raw pins on scl, sda, strap and chip clear.
//
// Behaviour
// - Device is target only; never drives the clock, never starts a transfer.
// - Decodes one of two seven-bit addresses by strap; bit 0 is read/write.
// - Strap low answers 1001100, strap high answers 1001110.
// - Port works at serial clock rates up to 10 MHz.
// - Start is data falling while clock high; device detects it.
// - Stop is data rising while clock high; device detects it.
// - Driver changes data only while clock is low.
// - Receiver pulls data low before ninth rise, holds until ninth fall.
// - Settings update only after four data bytes and a following stop.
// - Byte 3 holds rate select bit 7, revision bit 6, rest reserved.
// - Feedback ratio is 72 plus five-bit code, codes up to 16; default 80.
// - Rate select 0 gives 200 MHz pair, 1 gives 100 MHz.
// - Revision bit is a fixed revision indicator, default 1.
// - An output whose enable is clear goes to high impedance.
// - Chip clear resets dividers, loads defaults, floats outputs 0 to 11.
// - Bytes 0 and 1 hold enables 16..1; byte 2 enable 0, code, spread, bypass.
// - Defaults: ratio 80, spread off, loop as divider source.
`timescale 1ns/10ps
`include "csic_map.svh"

module csic_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_flush,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  import csic_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] count;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
  } csic_fifo_state_t;

  csic_fifo_state_t st;
  csic_fifo_state_t nx;
  logic do_push;
  logic do_pop;

  assign o_in_ready = (st.count != (AW+1)'(DEPTH));
  assign o_out_valid = (st.count != '0);
  assign o_out_data = st.mem[st.rd];
  assign do_push = i_in_valid && o_in_ready;
  assign do_pop = o_out_valid && i_out_ready;

  always_comb begin
    nx = st;
    if (i_flush) begin
      nx.count = '0;
      nx.wr = '0;
      nx.rd = '0;
    end else begin
      if (do_push) begin
        nx.mem[st.wr] = i_in_data;
        nx.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : AW'(st.wr + 1'b1);
      end
      if (do_pop) begin
        nx.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : AW'(st.rd + 1'b1);
      end
      case ({do_push, do_pop})
        2'b10: nx.count = (AW+1)'(st.count + 1'b1);
        2'b01: nx.count = (AW+1)'(st.count - 1'b1);
        default: nx.count = st.count;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end
endmodule

module csic_i2c_ctrl (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_chip_clear_n,
  input wire logic i_addr_select,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  output csic_pkg::csic_ctrl_t o_ctrl,
  output logic [6:0] o_fb_div_ratio,
  output logic [16:0] o_out_drive_en,
  output logic o_div_reset
);
  import csic_pkg::*;

  localparam logic [3:0][7:0] DefBytes = {`CSIC_BYTE3_RST, `CSIC_BYTE2_RST, `CSIC_BYTE1_RST, `CSIC_BYTE0_RST};
  localparam int AckBoundCyc = `CSIC_SCL_PERIOD_CYC / 2;

  // Maps the four bytes onto settings; revision and reserved bits never come from the bus
  function automatic csic_ctrl_t csic_unpack(input logic [3:0][7:0] b, input logic [4:0] keep_code,
                                             input logic keep_rev);
    csic_ctrl_t c;
    logic [4:0] code;
    code = b[2][`CSIC_B2_CODE_MSB:`CSIC_B2_CODE_LSB];
    c.out_en = {b[0], b[1], b[2][`CSIC_B2_OUT0_BIT]};
    c.fb_div_code = (code <= `CSIC_CODE_MAX) ? code : keep_code;
    c.spread_enable = b[2][`CSIC_B2_SPREAD_BIT];
    c.bypass_select = b[2][`CSIC_B2_BYPASS_BIT];
    c.hcsl_pair_rate_select = b[3][`CSIC_B3_RATE_BIT];
    c.revision = keep_rev;
    return c;
  endfunction

  localparam csic_ctrl_t CtrlDefault = csic_unpack(DefBytes, DefBytes[2][`CSIC_B2_CODE_MSB:`CSIC_B2_CODE_LSB],
                                                   DefBytes[3][`CSIC_B3_REV_BIT]);

  csic_top_state_t st;
  csic_top_state_t nx;

  logic scl_high;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic clear_on;
  logic addr_match;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_out_ready;
  logic apply_go;

  // Edges are taken from the second and third stages only; stage one feeds stage two alone
  assign scl_high = st.scl_sync[1] && st.scl_sync[2];
  assign scl_rise = st.scl_sync[1] && !st.scl_sync[2];
  assign scl_fall = !st.scl_sync[1] && st.scl_sync[2];
  assign start_seen = scl_high && !st.sda_sync[1] && st.sda_sync[2];
  assign stop_seen = scl_high && st.sda_sync[1] && !st.sda_sync[2];
  assign clear_on = !st.clr_sync[1];
  assign addr_match = (st.shift[7:1] == (st.adr_sync[1] ? `CSIC_ADDR_HIGH : `CSIC_ADDR_LOW))
                      && !st.shift[0];
  assign fifo_out_ready = (st.sh_idx < `CSIC_BYTE_COUNT) && !start_seen;
  assign apply_go = st.apply_pend && !fifo_out_valid && (st.sh_idx == `CSIC_BYTE_COUNT);

  csic_fifo #(
    .WIDTH(`CSIC_FIFO_WIDTH),
    .DEPTH(`CSIC_FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_flush(start_seen),
    .i_in_valid(st.push),
    .i_in_data(st.shift),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_data),
    .i_out_ready(fifo_out_ready)
  );

  always_comb begin
    nx = st;
    // Sampling at 250 MHz keeps every phase of a 10 MHz clock at a dozen cycles or more
    nx.scl_sync = {st.scl_sync[1:0], i_scl};
    nx.sda_sync = {st.sda_sync[1:0], i_sda};
    nx.adr_sync = {st.adr_sync[0], i_addr_select};
    nx.clr_sync = {st.clr_sync[0], i_chip_clear_n};
    nx.push = 1'b0;
    nx.sda_out = 1'b0;

    // Serial byte engine; the data line is only ever pulled low, the clock is never driven
    if (start_seen) begin
      nx.bus = BUS_ADDR;
      nx.bit_cnt = '0;
      nx.data_cnt = '0;
      nx.sda_oe = 1'b0;
      nx.apply_pend = 1'b0;
    end else if (stop_seen) begin
      if (st.data_cnt == `CSIC_BYTE_COUNT) begin
        nx.apply_pend = 1'b1;
      end
      nx.bus = BUS_IDLE;
      nx.sda_oe = 1'b0;
    end else if (scl_rise && (st.bus == BUS_ADDR || st.bus == BUS_DATA)) begin
      nx.shift = {st.shift[6:0], st.sda_sync[1]};
      nx.bit_cnt = 4'(st.bit_cnt + 1'b1);
    end else if (scl_fall) begin
      case (st.bus)
        BUS_ADDR: begin
          if (st.bit_cnt == `CSIC_BITS_PER_BYTE) begin
            if (addr_match) begin
              nx.bus = BUS_ADDR_ACK;
              nx.sda_oe = 1'b1;
            end else begin
              nx.bus = BUS_IGNORE;
            end
          end
        end
        BUS_DATA: begin
          if (st.bit_cnt == `CSIC_BITS_PER_BYTE) begin
            if (st.data_cnt < `CSIC_BYTE_COUNT && fifo_in_ready) begin
              nx.bus = BUS_DATA_ACK;
              nx.sda_oe = 1'b1;
              nx.push = 1'b1;
              nx.data_cnt = 3'(st.data_cnt + 1'b1);
            end else begin
              // A fifth byte is refused and spoils the transfer
              if (st.data_cnt == `CSIC_BYTE_COUNT) begin
                nx.data_cnt = `CSIC_BYTE_OVERRUN;
              end
              nx.bus = BUS_IGNORE;
            end
          end
        end
        BUS_ADDR_ACK, BUS_DATA_ACK: begin
          nx.sda_oe = 1'b0;
          nx.bus = BUS_DATA;
          nx.bit_cnt = '0;
        end
        default: begin
          nx.bus = st.bus;
        end
      endcase
    end

    // Shadow bytes fill from the FIFO and stay apart from the applied settings
    if (start_seen) begin
      nx.sh_idx = '0;
    end else if (fifo_out_valid && fifo_out_ready) begin
      nx.shadow[st.sh_idx[1:0]] = fifo_out_data;
      nx.sh_idx = 3'(st.sh_idx + 1'b1);
    end

    if (clear_on) begin
      nx.ctrl = CtrlDefault;
      nx.apply_pend = 1'b0;
    end else if (apply_go) begin
      nx.ctrl = csic_unpack(st.shadow, st.ctrl.fb_div_code, st.ctrl.revision);
      nx.apply_pend = 1'b0;
    end
    nx.ratio = `CSIC_RATIO_BASE + {2'b00, nx.ctrl.fb_div_code};
    nx.drive = nx.ctrl.out_en & ~(clear_on ? `CSIC_CLEAR_HIZ_MASK : 17'h00000);
    nx.div_reset = clear_on;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st <= '0;
      st.bus <= BUS_IDLE;
      // Synchronisers start at the idle bus level so reset gives no false edge
      st.scl_sync <= 3'h7;
      st.sda_sync <= 3'h7;
      st.clr_sync <= 2'h3;
      st.ctrl <= CtrlDefault;
      st.ratio <= `CSIC_RATIO_BASE + {2'b00, CtrlDefault.fb_div_code};
      st.drive <= CtrlDefault.out_en;
    end else begin
      st <= nx;
    end
  end

  assign o_sda_out = st.sda_out;
  assign o_sda_oe = st.sda_oe;
  assign o_ctrl = st.ctrl;
  assign o_fb_div_ratio = st.ratio;
  assign o_out_drive_en = st.drive;
  assign o_div_reset = st.div_reset;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);

  slave_only_a: assert property (st.sda_oe |-> (st.bus == BUS_ADDR_ACK || st.bus == BUS_DATA_ACK))
    else $error("data line driven outside an acknowledge slot");

  addr_ack_a: assert property ((scl_fall && !start_seen && !stop_seen && st.bus == BUS_ADDR
                                && st.bit_cnt == 4'h8 && addr_match) |=> (st.sda_oe && st.bus == BUS_ADDR_ACK))
    else $error("own write address not acknowledged");

  addr_nack_a: assert property ((scl_fall && !start_seen && !stop_seen && st.bus == BUS_ADDR
                                 && st.bit_cnt == 4'h8 && !addr_match) |=> (!st.sda_oe ##1 !st.sda_oe))
    else $error("foreign address acknowledged");

  start_detect_a: assert property ((scl_high && $fell(st.sda_sync[1])) |=>
                                   (st.bus == BUS_ADDR && st.bit_cnt == 4'h0 && st.data_cnt == 3'h0))
    else $error("start not detected");

  stop_detect_a: assert property ((scl_high && $rose(st.sda_sync[1])) |=> (st.bus == BUS_IDLE && !st.sda_oe))
    else $error("stop not detected");

  ack_timing_a: assert property ($rose(st.sda_oe) |-> !st.scl_sync[1] ##[0:AckBoundCyc] st.sda_oe)
    else $error("acknowledge driven while clock high");

  ack_hold_a: assert property ((st.sda_oe && !scl_fall && !start_seen && !stop_seen) |=> st.sda_oe)
    else $error("acknowledge released before clock fall");

  apply_gate_a: assert property ((st.ctrl != $past(st.ctrl)) |->
                                 ($past(apply_go) || $past(clear_on)))
    else $error("settings changed without completed transfer");

  ratio_range_a: assert property ((st.ratio == `CSIC_RATIO_BASE + {2'b00, st.ctrl.fb_div_code})
                                  && st.ctrl.fb_div_code <= `CSIC_CODE_MAX)
    else $error("feedback ratio out of step with code");

  rev_fixed_a: assert property (st.ctrl.revision == DefBytes[3][`CSIC_B3_REV_BIT])
    else $error("revision bit altered");

  drive_mask_a: assert property ((st.drive & ~st.ctrl.out_en) == 17'h00000)
    else $error("disabled output still driven");

  clear_load_a: assert property (clear_on |=> (st.ctrl == CtrlDefault && st.drive[11:0] == 12'h000
                                              && st.div_reset))
    else $error("chip clear did not restore defaults");

  apply_count_a: assert property (apply_go |-> st.data_cnt == `CSIC_BYTE_COUNT)
    else $error("settings applied without four data bytes");

  overrun_nack_a: assert property ((scl_fall && !start_seen && !stop_seen && st.bus == BUS_DATA
    && st.bit_cnt == 4'h8 && st.data_cnt == 3'h4) |=> (!st.sda_oe && st.data_cnt == 3'h5))
    else $error("fifth data byte acknowledged");

  short_hold_a: assert property ((stop_seen && st.data_cnt != 3'h4) |=> !st.apply_pend)
    else $error("short or spoiled transfer marked for apply");

  rate_apply_a: assert property ((apply_go && !clear_on) |=>
    (st.ctrl.hcsl_pair_rate_select == $past(st.shadow[3][`CSIC_B3_RATE_BIT])))
    else $error("rate select not taken from byte 3");

  push_room_a: assert property (st.push |-> fifo_in_ready)
    else $error("acknowledged byte pushed into a full buffer");

  div_hold_a: assert property (st.div_reset == $past(clear_on))
    else $error("divider reset out of step with chip clear");
endmodule

// *** src/csic_map.svh ***
// Constants of the synthesizer control port: addresses, byte layout, defaults, timing.
// Assumes inclusion by the package and the design file only.
`ifndef CSIC_MAP_SVH
`define CSIC_MAP_SVH

`define CSIC_ADDR_LOW 7'h4C
`define CSIC_ADDR_HIGH 7'h4E
`define CSIC_BYTE_COUNT 3'h4
`define CSIC_BYTE_OVERRUN 3'h5
`define CSIC_BITS_PER_BYTE 4'h8

`define CSIC_BYTE0_RST 8'hF7
`define CSIC_BYTE1_RST 8'hFF
`define CSIC_BYTE2_RST 8'hA0
`define CSIC_BYTE3_RST 8'h40

`define CSIC_B2_OUT0_BIT 7
`define CSIC_B2_CODE_MSB 6
`define CSIC_B2_CODE_LSB 2
`define CSIC_B2_SPREAD_BIT 1
`define CSIC_B2_BYPASS_BIT 0
`define CSIC_B3_RATE_BIT 7
`define CSIC_B3_REV_BIT 6

`define CSIC_RATIO_BASE 7'h48
`define CSIC_CODE_MAX 5'h10
`define CSIC_CLEAR_HIZ_MASK 17'h00FFF

`define CSIC_FIFO_WIDTH 8
`define CSIC_FIFO_DEPTH 8

`define CSIC_REF_PERIOD_PS 4000
`define CSIC_SCL_MIN_PERIOD_PS 100000
`define CSIC_SCL_PERIOD_CYC (`CSIC_SCL_MIN_PERIOD_PS / `CSIC_REF_PERIOD_PS)

`endif

// *** src/csic_pkg.sv ***
// Types of the synthesizer control port.
// Assumes csic_map.svh on the include path.
package csic_pkg;
  `include "csic_map.svh"

  typedef struct packed {
    logic [16:0] out_en;
    logic [4:0] fb_div_code;
    logic spread_enable;
    logic bypass_select;
    logic hcsl_pair_rate_select;
    logic revision;
  } csic_ctrl_t;

  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_ADDR_ACK,
    BUS_DATA,
    BUS_DATA_ACK,
    BUS_IGNORE
  } csic_bus_state_t;

  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic [1:0] adr_sync;
    logic [1:0] clr_sync;
    csic_bus_state_t bus;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [2:0] data_cnt;
    logic sda_out;
    logic sda_oe;
    logic push;
    logic [3:0][7:0] shadow;
    logic [2:0] sh_idx;
    logic apply_pend;
    csic_ctrl_t ctrl;
    logic [6:0] ratio;
    logic [16:0] drive;
    logic div_reset;
  } csic_top_state_t;
endpackage

// *** dv/csic_master_model.sv ***
// Serial bus master that sits on the far side of the control port.
// Assumes the data wire has a pull-up and is driven on falling edges of the reference clock.
`timescale 1ns/10ps
module csic_master_model (
  input wire logic i_ref_clk,
  input wire logic i_sda_oe,
  input wire logic i_sda_out,
  output logic o_scl,
  output logic o_sda
);
  logic sda_m = 1'b1;

  initial o_scl = 1'b1;

  // Wired-AND of both parties with the pull-up
  assign o_sda = (i_sda_oe && !i_sda_out) ? 1'b0 : sda_m;

  task automatic hc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  task automatic start();
    sda_m = 1'b0;
    hc(6);
    o_scl = 1'b0;
    hc(6);
  endtask

  task automatic stop();
    sda_m = 1'b0;
    hc(6);
    o_scl = 1'b1;
    hc(6);
    sda_m = 1'b1;
    hc(6);
  endtask

  // Eight data bits then a released ninth bit; 24 cycles a bit, just above 10 MHz
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic [8:0] w;
    w = {b, 1'b1};
    ack = 1'b0;
    for (int i = 8; i >= 0; i--) begin
      sda_m = w[i];
      hc(6);
      o_scl = 1'b1;
      hc(1);
      ack = ~o_sda;
      hc(11);
      ack = ack & ~o_sda;
      o_scl = 1'b0;
      hc(6);
    end
  endtask
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench of the synthesizer control port.
// Assumes csic_pkg is compiled first and the master model drives the serial pins.
`timescale 1ns/10ps
module tb_top;
  import csic_pkg::*;

  typedef struct packed {
    logic strap;
    logic [31:0] d;
    logic [6:0] ratio;
    logic [16:0] drive;
  } csic_row_t;

  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_chip_clear_n = 1'b1;
  logic i_addr_select = 1'b0;
  logic scl, sda, sda_out, sda_oe, div_reset;
  csic_ctrl_t ctrl, cur;
  logic [6:0] ratio;
  logic [16:0] drive;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  csic_row_t rows [5] = '{
    '{1'b0, 32'hFFFF8000, 7'h48, 17'h1FFFF},
    '{1'b1, 32'h000043BF, 7'h58, 17'h00000},
    '{1'b0, 32'hA55ABD7F, 7'h57, 17'h14AB5},
    '{1'b1, 32'hF7FFA040, 7'h50, 17'h1EFFF},
    '{1'b0, 32'h1234FF80, 7'h50, 17'h02469}};

  always #2 i_ref_clk = ~i_ref_clk;

  csic_master_model u_csic_master_model (
    .i_ref_clk(i_ref_clk), .i_sda_oe(sda_oe), .i_sda_out(sda_out), .o_scl(scl), .o_sda(sda));

  csic_i2c_ctrl u_csic_i2c_ctrl (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_chip_clear_n(i_chip_clear_n),
    .i_addr_select(i_addr_select), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .o_ctrl(ctrl), .o_fb_div_ratio(ratio), .o_out_drive_en(drive),
    .o_div_reset(div_reset));

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic chk_ack(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // Settings expected once a full write of bytes d is applied over old
  function automatic csic_ctrl_t nxt(input logic [31:0] d, input csic_ctrl_t old);
    csic_ctrl_t c;
    c.out_en = {d[31:16], d[15]};
    c.fb_div_code = (d[14:10] > 5'h10) ? old.fb_div_code : d[14:10];
    c.spread_enable = d[9];
    c.bypass_select = d[8];
    c.hcsl_pair_rate_select = d[7];
    c.revision = 1'b1;
    return c;
  endfunction

  // Address byte then n data bytes; settings must hold until the stop
  task automatic frame(input logic [7:0] a, input logic [39:0] d, input int n, input logic ok);
    logic ack;
    u_csic_master_model.start();
    u_csic_master_model.put_byte(a, ack);
    chk_ack(ack, ok);
    for (int i = 0; i < n; i++) begin
      u_csic_master_model.put_byte(d[39-8*i -: 8], ack);
      chk_ack(ack, ok && i < 4);
    end
    chk(ctrl, cur);
    u_csic_master_model.stop();
    repeat (6) @(negedge i_ref_clk);
  endtask

  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (12) @(negedge i_ref_clk);
    i_reset = 1'b0;
    repeat (6) @(negedge i_ref_clk);
    cur = nxt(32'hF7FFA040, cur);
    chk(ctrl, cur);
    chk(ratio, 7'h50);
    chk(drive, 17'h1EFFF);
    chk(sda_oe, 1'b0);
    chk(sda_out, 1'b0);
    foreach (rows[k]) begin
      i_addr_select = rows[k].strap;
      repeat (4) @(negedge i_ref_clk);
      frame({rows[k].strap ? 7'b1001110 : 7'b1001100, 1'b0}, {rows[k].d, 8'h00}, 4, 1'b1);
      cur = nxt(rows[k].d, cur);
      chk(ctrl, cur);
      chk(ratio, rows[k].ratio);
      chk(drive, rows[k].drive);
    end
    // Strap is low: the other address and a read are both refused
    frame({7'b1001110, 1'b0}, 40'h0, 4, 1'b0);
    frame({7'b1001100, 1'b1}, 40'h0, 1, 1'b0);
    // Short transfer, then one byte too many: neither applies
    frame({7'b1001100, 1'b0}, 40'h0, 3, 1'b1);
    frame({7'b1001100, 1'b0}, 40'h00000000FF, 5, 1'b1);
    chk(ctrl, cur);
    chk(ratio, 7'h50);
    // Chip clear loads defaults and floats outputs 0 to 11
    i_chip_clear_n = 1'b0;
    repeat (6) @(negedge i_ref_clk);
    cur = nxt(32'hF7FFA040, cur);
    chk(div_reset, 1'b1);
    chk(ctrl, cur);
    chk(drive, 17'h1E000);
    i_chip_clear_n = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    chk(div_reset, 1'b0);
    chk(drive, 17'h1EFFF);
    // Mid-run reset after a full write brings the defaults back
    frame({7'b1001100, 1'b0}, {32'h000043BF, 8'h00}, 4, 1'b1);
    cur = nxt(32'h000043BF, cur);
    chk(ctrl, cur);
    i_reset = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    i_reset = 1'b0;
    repeat (6) @(negedge i_ref_clk);
    cur = nxt(32'hF7FFA040, cur);
    chk(ctrl, cur);
    chk(ratio, 7'h50);
    chk(drive, 17'h1EFFF);
    chk(sda_oe, 1'b0);
    tally_and_finish();
  end
endmodule
